/* slcr_cfg_reg.sv */
`timescale 1ns/1ns
`default_nettype none

// one writable configuration field with its own reset value
module slcr_cfg_reg
    import slcr_pkg::*;
#(
    parameter int          WIDTH     = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    // write side, already qualified by the caller
    input  wire logic             i_wr_en,
    input  wire logic [WIDTH-1:0] i_wdata,
    // stored value
    output var  logic [WIDTH-1:0] o_value
);

    logic [WIDTH-1:0] value_q;   // stored field
    logic [WIDTH-1:0] value_d;   // next value

    // hold unless a qualified write lands
    assign value_d = i_wr_en ? i_wdata : value_q;

    // storage
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            value_q <= RESET_VAL;
        else
            value_q <= value_d;
    end

    assign o_value = value_q;

endmodule

`default_nettype wire

/* slcr_core_model.sv */
`timescale 1ns/1ns
`default_nettype none

// stand-in for the link receiver core: soft reset level and lane seven deskew events
module slcr_core_model
    import slcr_pkg::*;
#(
    parameter bit SKIP_LANE_ALIGNMENT = 1'b0 // alignment runs, so the status bit is meaningful
)
(
    // clock
    input  wire logic i_clk,
    // towards the register block
    output var  logic o_soft_rst,
    output var  logic o_done,
    output var  logic o_fail
);
    // quiet at time zero
    initial
    begin
        o_soft_rst = 1'b0;
        o_done     = 1'b0;
        o_fail     = 1'b0;
    end

    // software may only reconfigure while this level is held high
    task automatic hold_reset(input logic on);
        @(negedge i_clk);
        o_soft_rst = on;
    endtask

    // one-cycle deskew outcome; both high is allowed to probe priority
    task automatic pulse(input logic d, input logic f);
        @(negedge i_clk);
        o_done = d;
        o_fail = f;
        @(negedge i_clk);
        o_done = 1'b0;
        o_fail = 1'b0;
    endtask
endmodule

`default_nettype wire

/* slcr_deskew_flag.sv */
`timescale 1ns/1ns
`default_nettype none

// per-lane deskew status: set on success, cleared on failure or restart
module slcr_deskew_flag
    import slcr_pkg::*;
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    // events from the link receiver core, same clock
    input  wire logic i_achieved,
    input  wire logic i_failed,
    input  wire logic i_restart,
    // status bit
    output var  logic o_flag
);

    logic flag_q;   // status flop
    logic flag_d;   // next status

    // success wins over a clear arriving in the same cycle
    assign flag_d = i_achieved ? 1'b1 : ((i_failed | i_restart) ? 1'b0 : flag_q);

    // storage, deskew not complete after reset
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            flag_q <= 1'b0;
        else
            flag_q <= flag_d;
    end

    assign o_flag = flag_q;

    a_flag_set_wins : assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_achieved |=> o_flag)
        else $error("deskew flag not set after success");

endmodule

`default_nettype wire

/* slcr_lane_cfg.sv */
// Behaviour
// - bits per sample field reads fixed fifteen
// - samples per frame minus one, read-only
// - density flag bit seven, resets high
// - control words per frame read zero
// - two writable reserved bytes, reset zero
// - written checksum is lane zero expectation
// - lane seven deskew status, resets zero
`timescale 1ns/1ns
`default_nettype none
`include "slcr_regs.svh"

module slcr_lane_cfg
    import slcr_pkg::*;
#(
    parameter int SAMPLES_PER_FRAME = `SLCR_SAMPLES_FRAME,  // valid settings are one and two
    parameter bit HIGH_DENSITY      = `SLCR_DENSITY_HIGH    // density mode reported to software
)
(
    // clock and reset
    input  wire logic          i_clk,
    input  wire logic          i_sys_rst,
    // register port
    input  wire slcr_addr_type i_reg_addr,
    input  wire logic          i_reg_wr,
    input  wire logic          i_reg_rd,
    input  wire slcr_byte_type i_reg_wdata,
    output var  slcr_byte_type o_reg_rdata,
    output var  logic          o_reg_rvalid,
    // link receiver core side
    input  wire logic          i_core_soft_rst,
    input  wire logic          i_lane7_deskew_done,
    input  wire logic          i_lane7_deskew_fail,
    output var  logic [2:0]    o_link_standard_version,
    output var  slcr_byte_type o_reserved_cfg_one,
    output var  slcr_byte_type o_reserved_cfg_two,
    output var  slcr_byte_type o_lane_zero_checksum,
    output var  logic          o_lane7_deskew_ok
);

    // address compare, used for every register
    function automatic logic addr_hit(input slcr_addr_type addr, input slcr_addr_type off);
        addr_hit = (addr == off);
    endfunction

    // fixed read-only field values
    localparam logic [4:0] SAMPLES_FIELD = 5'(SAMPLES_PER_FRAME - 1);   // stored minus one

    // register decode
    wire hit_bits    = addr_hit(i_reg_addr, `SLCR_OFF_SAMPLE_BITS);
    wire hit_samples = addr_hit(i_reg_addr, `SLCR_OFF_SAMPLES_FRAME);
    wire hit_density = addr_hit(i_reg_addr, `SLCR_OFF_DENSITY_CW);
    wire hit_res_one = addr_hit(i_reg_addr, `SLCR_OFF_RES_ONE);
    wire hit_res_two = addr_hit(i_reg_addr, `SLCR_OFF_RES_TWO);
    wire hit_chk     = addr_hit(i_reg_addr, `SLCR_OFF_CHECKSUM);
    wire hit_deskew  = addr_hit(i_reg_addr, `SLCR_OFF_DESKEW);
    // no register here, so the read answers zero
    wire hit_none    = ~(hit_bits | hit_samples | hit_density | hit_res_one
                         | hit_res_two | hit_chk | hit_deskew);

    // writes land only while the core is held in soft reset, so a stray
    // write during operation cannot disturb a running link
    wire wr_ok      = i_reg_wr & i_core_soft_rst;
    wire wr_version = wr_ok & hit_samples;
    wire wr_res_one = wr_ok & hit_res_one;
    wire wr_res_two = wr_ok & hit_res_two;
    wire wr_chk     = wr_ok & hit_chk;

    // stored fields
    logic [2:0]    version_val;   // link standard version
    slcr_byte_type res_one_val;   // reserved field one
    slcr_byte_type res_two_val;   // reserved field two
    slcr_byte_type chk_val;       // expected checksum
    logic          deskew_val;    // lane seven deskew status

    // version field, upper bits of the samples register
    slcr_cfg_reg #(
        .WIDTH     (3),
        .RESET_VAL (`SLCR_RST_VERSION)
    ) u_version (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_wr_en   (wr_version),
        .i_wdata   (i_reg_wdata[`SLCR_VER_MSB:`SLCR_VER_LSB]),
        .o_value   (version_val)
    );

    // reserved field one, part of the checksummed set
    slcr_cfg_reg #(
        .WIDTH     (8),
        .RESET_VAL (`SLCR_RST_RES_ONE)
    ) u_res_one (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_wr_en   (wr_res_one),
        .i_wdata   (i_reg_wdata),
        .o_value   (res_one_val)
    );

    // reserved field two, part of the checksummed set
    slcr_cfg_reg #(
        .WIDTH     (8),
        .RESET_VAL (`SLCR_RST_RES_TWO)
    ) u_res_two (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_wr_en   (wr_res_two),
        .i_wdata   (i_reg_wdata),
        .o_value   (res_two_val)
    );

    // checksum; the block trusts the value software computed over the
    // configuration bytes and does not recompute it here
    slcr_cfg_reg #(
        .WIDTH     (8),
        .RESET_VAL (`SLCR_RST_CHECKSUM)
    ) u_checksum (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_wr_en   (wr_chk),
        .i_wdata   (i_reg_wdata),
        .o_value   (chk_val)
    );

    // lane seven deskew status, restarted in each soft reset cycle that brings no success
    slcr_deskew_flag u_deskew7 (
        .i_clk      (i_clk),
        .i_sys_rst  (i_sys_rst),
        .i_achieved (i_lane7_deskew_done),
        .i_failed   (i_lane7_deskew_fail),
        .i_restart  (i_core_soft_rst),
        .o_flag     (deskew_val)
    );

    // read values per register; unused upper bits read zero
    wire slcr_byte_type rd_bits    = {3'h0, `SLCR_SAMPLE_BITS};
    wire slcr_byte_type rd_samples = {version_val, SAMPLES_FIELD};
    wire slcr_byte_type rd_density = {HIGH_DENSITY, 2'h0, `SLCR_CTRL_WORDS};
    wire slcr_byte_type rd_deskew  = {deskew_val, 7'h00};

    // read select; unmapped addresses answer zero
    wire slcr_byte_type rd_sel =
        hit_bits    ? rd_bits    :
        hit_samples ? rd_samples :
        hit_density ? rd_density :
        hit_res_one ? res_one_val :
        hit_res_two ? res_two_val :
        hit_chk     ? chk_val    :
        hit_deskew  ? rd_deskew  : 8'h00;

    // read data and valid, registered one cycle after the strobe
    slcr_byte_type rdata_q;    // read data flop
    slcr_byte_type rdata_d;    // next read data
    logic          rvalid_q;   // read answer flag
    logic          rvalid_d;   // next answer flag

    assign rdata_d  = i_reg_rd ? rd_sel : rdata_q;
    assign rvalid_d = i_reg_rd;

    // read answer register
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // outputs, all from flops
    assign o_reg_rdata             = rdata_q;
    assign o_reg_rvalid            = rvalid_q;
    assign o_link_standard_version = version_val;
    assign o_reserved_cfg_one      = res_one_val;
    assign o_reserved_cfg_two      = res_two_val;
    assign o_lane_zero_checksum    = chk_val;
    assign o_lane7_deskew_ok       = deskew_val;

    // read answers one cycle after the strobe
    a_read_latency : assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_reg_rd |=> o_reg_rvalid)
        else $error("read answer missing");

    // bits per sample reads fifteen
    a_np_fixed_value : assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_reg_rd && i_reg_addr == `SLCR_OFF_SAMPLE_BITS) |=> (o_reg_rdata == 8'h0f))
        else $error("bits per sample field wrong");

    // samples field reads configured count minus one, version above it
    a_samples_field : assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_reg_rd && i_reg_addr == `SLCR_OFF_SAMPLES_FRAME)
        |=> (o_reg_rdata[4:0] == SAMPLES_FIELD) && (o_reg_rdata[7:5] == $past(o_link_standard_version)))
        else $error("samples field wrong");

    // density flag high
    a_density_high : assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_reg_rd && i_reg_addr == `SLCR_OFF_DENSITY_CW) |=> (o_reg_rdata[7] == HIGH_DENSITY))
        else $error("density flag wrong");

    // control words and reserved bits read zero
    a_ctrl_words_zero : assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_reg_rd && i_reg_addr == `SLCR_OFF_DENSITY_CW) |=> (o_reg_rdata[6:0] == 7'h00))
        else $error("control word count not zero");

    // reserved field one takes a write made during soft reset
    a_res_one_write : assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_reg_wr && i_core_soft_rst && i_reg_addr == `SLCR_OFF_RES_ONE)
        |=> (o_reserved_cfg_one == $past(i_reg_wdata)))
        else $error("reserved field one write lost");

    // configuration holds still while the core runs
    a_cfg_stable_run : assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!$past(i_core_soft_rst) && !$past(i_sys_rst))
        |-> ($stable(o_reserved_cfg_one) && $stable(o_reserved_cfg_two)
            && $stable(o_lane_zero_checksum) && $stable(o_link_standard_version)))
        else $error("configuration changed outside soft reset");

    // checksum read back matches the value handed to the core
    a_chk_readback : assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_reg_rd && i_reg_addr == `SLCR_OFF_CHECKSUM && !i_reg_wr) |=> (o_reg_rdata == o_lane_zero_checksum))
        else $error("checksum readback mismatch");

    // reset clears checksum, version and deskew status
    a_reset_values : assert property (@(posedge i_clk)
        i_sys_rst |=> (o_lane_zero_checksum == 8'h00) && (o_link_standard_version == 3'h0) && !o_lane7_deskew_ok
            && (o_reserved_cfg_one == 8'h00) && (o_reserved_cfg_two == 8'h00))
        else $error("reset values wrong");

    // failure without success clears the status bit
    a_deskew_clear : assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_lane7_deskew_fail && !i_lane7_deskew_done) |=> !o_lane7_deskew_ok)
        else $error("deskew status not cleared");

    // deskew bit shows on the register port
    a_deskew_read : assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_reg_rd && i_reg_addr == `SLCR_OFF_DESKEW) |=> (o_reg_rdata == {$past(o_lane7_deskew_ok), 7'h00}))
        else $error("deskew read wrong");

    // the answer flag stands only in cycles that follow a read strobe
    a_rvalid_single : assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !i_reg_rd |=> !o_reg_rvalid)
        else $error("read answer held too long");

    // read data holds between reads, so software may sample it late
    a_rdata_holds : assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data moved without a read");

    // unmapped addresses answer zero
    a_unmapped_zero : assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_reg_rd && hit_none) |=> (o_reg_rdata == 8'h00))
        else $error("unmapped read not zero");

    // reserved field two takes a write made during soft reset
    a_res_two_write : assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_reg_wr && i_core_soft_rst && i_reg_addr == `SLCR_OFF_RES_TWO)
        |=> (o_reserved_cfg_two == $past(i_reg_wdata)))
        else $error("reserved field two write lost");

    // reserved fields read back what is stored
    a_res_one_read : assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_reg_rd && hit_res_one && !i_reg_wr) |=> (o_reg_rdata == o_reserved_cfg_one))
        else $error("reserved field one readback wrong");

    a_res_two_read : assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_reg_rd && hit_res_two && !i_reg_wr) |=> (o_reg_rdata == o_reserved_cfg_two))
        else $error("reserved field two readback wrong");

    // checksum takes a write made during soft reset
    a_chk_write : assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_reg_wr && i_core_soft_rst && i_reg_addr == `SLCR_OFF_CHECKSUM)
        |=> (o_lane_zero_checksum == $past(i_reg_wdata)))
        else $error("checksum write lost");

    // version takes the upper three bits of a guarded write
    a_version_write : assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_reg_wr && i_core_soft_rst && i_reg_addr == `SLCR_OFF_SAMPLES_FRAME)
        |=> (o_link_standard_version == $past(i_reg_wdata[`SLCR_VER_MSB:`SLCR_VER_LSB])))
        else $error("version write lost");

    // a write while the core runs leaves every field alone
    a_write_refused : assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_reg_wr && !i_core_soft_rst) |=> ($stable(o_reserved_cfg_one) && $stable(o_reserved_cfg_two)
            && $stable(o_lane_zero_checksum) && $stable(o_link_standard_version)))
        else $error("write landed while core ran");

    // success sets the status bit
    a_deskew_set : assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_lane7_deskew_done |=> o_lane7_deskew_ok)
        else $error("deskew status not set");

    // soft reset without success restarts the status
    a_restart_clear : assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_core_soft_rst && !i_lane7_deskew_done) |=> !o_lane7_deskew_ok)
        else $error("deskew status survived restart");

    // with no event the status holds
    a_deskew_holds : assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!i_lane7_deskew_done && !i_lane7_deskew_fail && !i_core_soft_rst) |=> $stable(o_lane7_deskew_ok))
        else $error("deskew status moved without event");

endmodule

`default_nettype wire

/* slcr_pkg.sv */
package slcr_pkg;

    // register port address and data
    typedef logic [11:0] slcr_addr_type;
    typedef logic [7:0]  slcr_byte_type;

endpackage

/* slcr_regs.svh */
`ifndef SLCR_REGS_SVH
`define SLCR_REGS_SVH

// register offsets on the register port
`define SLCR_OFF_SAMPLE_BITS   12'h458
`define SLCR_OFF_SAMPLES_FRAME 12'h459
`define SLCR_OFF_DENSITY_CW    12'h45a
`define SLCR_OFF_RES_ONE       12'h45b
`define SLCR_OFF_RES_TWO       12'h45c
`define SLCR_OFF_CHECKSUM      12'h45d
`define SLCR_OFF_DESKEW        12'h46c

// field positions
`define SLCR_VER_MSB           7
`define SLCR_VER_LSB           5
`define SLCR_LOW5_MSB          4
`define SLCR_DENSITY_BIT       7
`define SLCR_DESKEW7_BIT       7

// reset and fixed values
`define SLCR_RST_VERSION       3'h0
`define SLCR_RST_RES_ONE       8'h00
`define SLCR_RST_RES_TWO       8'h00
`define SLCR_RST_CHECKSUM      8'h00
`define SLCR_SAMPLE_BITS       5'h0f
`define SLCR_SAMPLES_FRAME     5'h02
`define SLCR_DENSITY_HIGH      1'h1
`define SLCR_CTRL_WORDS        5'h00
`define SLCR_VERSION_SUPPORTED 3'h1

`endif

/* test_slcr_lane_cfg.sv */
`timescale 1ns/1ns
`default_nettype none

module test_slcr_lane_cfg
    import slcr_pkg::*;
;
    logic          i_clk;       // 100 MHz clock
    logic          i_sys_rst;   // sync reset
    slcr_addr_type addr;        // register address
    logic          wr;          // write strobe
    logic          rd;          // read strobe
    slcr_byte_type wdata;       // write data
    slcr_byte_type rdata;       // read data
    logic          rvalid;      // read answer
    logic          soft_rst;    // core soft reset
    logic          done;        // deskew achieved
    logic          fail;        // deskew failed
    logic [2:0]    ver;         // version field
    slcr_byte_type reserved_cfg_one;        // reserved one
    slcr_byte_type reserved_cfg_two;        // reserved two
    slcr_byte_type cks;         // lane zero checksum
    logic          ok;          // deskew status
    slcr_byte_type exp_q[$];    // expected read data, oldest first
    slcr_byte_type r1;          // random reserved one
    slcr_byte_type r2;          // random reserved two
    slcr_byte_type sum;         // checksum software would write
    int            failures;    // mismatches
    int            n_checks;    // comparisons
    slcr_addr_type ra[8] = '{12'h458, 12'h459, 12'h45a, 12'h45b, 12'h45c, 12'h45d, 12'h46c, 12'h460};
    slcr_byte_type re[8] = '{8'h0f, 8'h01, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    // clock
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    slcr_lane_cfg u_dut (
        .i_clk                   (i_clk),
        .i_sys_rst               (i_sys_rst),
        .i_reg_addr              (addr),
        .i_reg_wr                (wr),
        .i_reg_rd                (rd),
        .i_reg_wdata             (wdata),
        .o_reg_rdata             (rdata),
        .o_reg_rvalid            (rvalid),
        .i_core_soft_rst         (soft_rst),
        .i_lane7_deskew_done     (done),
        .i_lane7_deskew_fail     (fail),
        .o_link_standard_version (ver),
        .o_reserved_cfg_one      (reserved_cfg_one),
        .o_reserved_cfg_two      (reserved_cfg_two),
        .o_lane_zero_checksum    (cks),
        .o_lane7_deskew_ok       (ok)
    );

    slcr_core_model u_core (
        .i_clk      (i_clk),
        .o_soft_rst (soft_rst),
        .o_done     (done),
        .o_fail     (fail)
    );

    // one comparison, four-state exact
    task automatic chk(input string name, input slcr_byte_type e, input slcr_byte_type g);
        n_checks++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask

    // strobes rise and fall on falling edges, so each is seen at exactly one rising edge
    task automatic rd_exp(input slcr_addr_type a, input slcr_byte_type e);
        @(negedge i_clk);
        addr = a;
        rd   = 1'b1;
        exp_q.push_back(e);
        @(negedge i_clk);
        rd = 1'b0;
    endtask

    task automatic wr_reg(input slcr_addr_type a, input slcr_byte_type d);
        @(negedge i_clk);
        addr  = a;
        wdata = d;
        wr    = 1'b1;
        @(negedge i_clk);
        wr = 1'b0;
    endtask

    // answer watcher: sampled just after the edge so the registered pulse has landed
    always @(posedge i_clk)
    begin
        #1;
        if (rvalid === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("unexpected rvalid", 8'h00, 8'hff);
            else
                chk("rdata", exp_q.pop_front(), rdata);
        end
    end

    task automatic final_report;
        if (exp_q.size() != 0)
            failures++;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // hang guard, far beyond the roughly sixty-five cycles the sequence needs
    initial
    begin
        #200000;
        failures++;
        final_report();
    end

    // main sequence
    initial
    begin
        i_sys_rst = 1'b1;
        addr      = '0;
        wr        = 1'b0;
        rd        = 1'b0;
        wdata     = '0;
        failures  = 0;
        n_checks  = 0;
        r1        = 8'($urandom(79));
        repeat (6) @(posedge i_clk);
        @(negedge i_clk);
        i_sys_rst = 1'b0;
        // reset image and fixed fields, plus one unmapped place
        for (int i = 0; i < 8; i++)
            rd_exp(ra[i], re[i]);
        chk("ok reset", 8'h00, {7'h0, ok});
        // writes while the core runs must not land
        wr_reg(12'h45b, 8'h5a);
        chk("reserved_cfg_one unguarded", 8'h00, reserved_cfg_one);
        u_core.hold_reset(1'b1);
        r1 = 8'($urandom());
        r2 = 8'($urandom());
        wr_reg(12'h45b, r1);
        wr_reg(12'h45c, r2);
        wr_reg(12'h459, 8'hff); // low five bits are read-only
        wr_reg(12'h458, 8'h00); // read-only byte
        // bytes below 0x458 lie outside this block and count as zero
        sum = 8'h0f + 8'he1 + 8'h80 + r1 + r2;
        wr_reg(12'h45d, sum);
        chk("reserved_cfg_one", r1, reserved_cfg_one);
        chk("reserved_cfg_two", r2, reserved_cfg_two);
        chk("version", 8'h07, {5'h0, ver});
        chk("checksum", sum, cks);
        rd_exp(12'h459, 8'he1);
        rd_exp(12'h458, 8'h0f);
        rd_exp(12'h45d, sum);
        u_core.hold_reset(1'b0);
        wr_reg(12'h45d, ~sum);
        rd_exp(12'h45d, sum);
        // deskew status follows the core's outcome
        u_core.pulse(1'b1, 1'b0);
        chk("ok done", 8'h01, {7'h0, ok});
        rd_exp(12'h46c, 8'h80);
        u_core.pulse(1'b0, 1'b1);
        chk("ok fail", 8'h00, {7'h0, ok});
        u_core.pulse(1'b1, 1'b1);
        chk("ok both", 8'h01, {7'h0, ok});
        u_core.hold_reset(1'b1);
        @(negedge i_clk);
        chk("ok restart", 8'h00, {7'h0, ok});
        // second reset mid-run restores writable fields
        i_sys_rst = 1'b1;
        @(negedge i_clk);
        i_sys_rst = 1'b0;
        chk("reserved_cfg_one rerst", 8'h00, reserved_cfg_one);
        chk("ver rerst", 8'h00, {5'h0, ver});
        chk("cks rerst", 8'h00, cks);
        rd_exp(12'h45a, 8'h80);
        repeat (3) @(negedge i_clk);
        final_report();
    end
endmodule

`default_nettype wire
